//--- verilog/scale_msg_pkg.sv
package scale_msg_pkg;
  // Weight and code widths
  localparam int WEIGHT_W = 24;
  localparam int ACC_W = 24;
  localparam int ACCESS_W = 5;
  localparam int SERVICE_W = 12;
  // Overrange default threshold in per-mille of capacity (about 4% over)
  localparam logic [10:0] OVR_PERMILLE_DEF = 11'h410;
  localparam logic [WEIGHT_W-1:0] CAPACITY_DEF = 24'h002710;
  localparam logic [ACC_W-1:0] ACC_MAX = 24'h98967F;
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int NOTICE_MS = 1000;
  localparam int NOTICE_CYC = CLK_HZ / 1000 * NOTICE_MS;
  localparam int MARCH_MS = 200;
  localparam int MARCH_CYC = CLK_HZ / 1000 * MARCH_MS;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  // Low battery lamp threshold: remaining minutes of remote operation
  localparam int LOWBAT_MIN = 90;
  localparam logic [7:0] LOWBAT_MIN_V = 8'h5A;
  // Fault codes
  localparam logic [3:0] FAULT_MEM = 4'h1;
  localparam logic [3:0] FAULT_PROG = 4'h2;
  localparam logic [3:0] FAULT_BACKUP_LOST = 4'h3;
  localparam logic [3:0] FAULT_BACKUP_STORE = 4'h4;
  localparam logic [3:0] FAULT_ACCESS = 4'h5;
  // Interrupt status bit positions
  localparam int EV_OVR = 0;
  localparam int EV_ACC_FULL = 1;
  localparam int EV_LOS = 2;
  localparam int EV_SHUTOFF = 3;
  localparam int EV_FAULT = 4;
  localparam int EV_CAL = 5;
  localparam int EV_W = 6;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CAPACITY = 4'h1;
  localparam logic [3:0] REG_TARE = 4'h2;
  localparam logic [3:0] REG_ACC = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_INT_STAT = 4'h5;
  localparam logic [3:0] REG_INT_EN = 4'h6;
  localparam logic [3:0] REG_INT_CLR = 4'h7;
  localparam logic [3:0] REG_FAULT = 4'h8;
  localparam logic [3:0] REG_CALNUM = 4'h9;
  // Control register fields
  localparam int CTRL_NET = 0;
  localparam int CTRL_ACC_CLEAR = 1;
  localparam int CTRL_OVR_LO = 8;
  // Display message selector
  typedef enum logic [2:0] {
    MSG_WEIGHT, MSG_OVERRANGE, MSG_LOS, MSG_FAULT, MSG_SHUTOFF,
    MSG_CAL_ON, MSG_CAL_OFF, MSG_CALNUM
  } msg_e;
endpackage : scale_msg_pkg

//--- verilog/scale_status_message_logic.sv
`timescale 1ns/1ps
module scale_status_message_logic #(
  parameter int NOTICE_CYCLES = scale_msg_pkg::NOTICE_CYC,
  parameter int MARCH_CYCLES = scale_msg_pkg::MARCH_CYC,
  parameter int FLASH_CYCLES = scale_msg_pkg::FLASH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Telemetry frames from the link decoder (same clock)
  input wire logic frame_valid,
  input wire logic [scale_msg_pkg::WEIGHT_W-1:0] frame_weight,
  input wire logic [scale_msg_pkg::ACCESS_W-1:0] frame_access,
  input wire logic frame_shutoff,
  input wire logic frame_powerup,
  input wire logic [scale_msg_pkg::WEIGHT_W-1:0] frame_calnum,
  input wire logic [7:0] frame_bat_minutes,
  input wire logic signal_lost,
  // Front panel request and pins
  input wire logic accumulate_req,
  input wire logic cal_switch,
  input wire logic [scale_msg_pkg::ACCESS_W-1:0] access_switch,
  // Self-test results
  input wire logic selftest_done,
  input wire logic mem_fail,
  input wire logic prog_fail,
  input wire logic backup_lost,
  input wire logic backup_store_fail,
  input wire logic [scale_msg_pkg::SERVICE_W-1:0] backup_service,
  // Display and printer
  output scale_msg_pkg::msg_e display_msg,
  output logic [scale_msg_pkg::WEIGHT_W-1:0] display_value,
  output logic [3:0] fault_code,
  output logic [scale_msg_pkg::SERVICE_W-1:0] fault_service,
  output logic [3:0] march_pos,
  output logic low_battery_lamp,
  output logic weighing_enable,
  output logic print_fault_valid,
  input wire logic print_fault_ready,
  output logic [15:0] print_fault_word,
  // Interrupt
  output logic irq
);

  localparam int WW = scale_msg_pkg::WEIGHT_W;
  localparam int EW = scale_msg_pkg::EV_W;

  typedef enum {ST_SELFTEST, ST_FAULT, ST_RUN} boot_e;

  // Pin synchronisers for the calibration switch and access straps
  logic cal_s1_q, cal_s2_q, cal_s3_q;
  logic [scale_msg_pkg::ACCESS_W-1:0] acc_s1_q, acc_s2_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cal_s1_q <= 1'b0;
      cal_s2_q <= 1'b0;
      cal_s3_q <= 1'b0;
      acc_s1_q <= '0;
      acc_s2_q <= '0;
    end else begin
      cal_s1_q <= cal_switch;
      cal_s2_q <= cal_s1_q;
      cal_s3_q <= cal_s2_q;
      acc_s1_q <= access_switch;
      acc_s2_q <= acc_s1_q;
    end
  end

  // Registers
  logic net_q, net_d;
  logic [10:0] ovr_pm_q, ovr_pm_d;
  logic [WW-1:0] cap_q, cap_d, tare_q, tare_d, acc_q, acc_d;
  logic [EW-1:0] ist_q, ist_d, ien_q, ien_d;
  logic [EW-1:0] ev;
  logic [31:0] rdata_d;

  // Boot, fault and notice state
  boot_e boot_q, boot_d;
  logic [3:0] code_q, code_d;
  logic [scale_msg_pkg::SERVICE_W-1:0] svc_q, svc_d;
  logic print_pend_q, print_pend_d;
  logic boot_cal_q, boot_cal_d;
  scale_msg_pkg::msg_e notice_q, notice_d;
  logic [31:0] ntimer_q, ntimer_d;
  logic shutoff_q, shutoff_d;
  logic [WW-1:0] weight_q, weight_d, calnum_q, calnum_d;
  logic acc_full_q, acc_full_d;
  logic [31:0] march_cnt_q, march_cnt_d, flash_cnt_q, flash_cnt_d;
  logic [3:0] march_q, march_d;
  logic flash_q, flash_d;
  logic bat_low_q, bat_low_d;

  // Gross weight against capacity scaled by the configured per-mille
  logic [WW:0] gross;
  logic [WW+11:0] gross_pm, limit_pm;
  logic overrange;
  logic [WW:0] acc_sum;
  logic acc_overflow;
  logic cal_rise, cal_fall;

  always_comb begin
    gross = {1'b0, weight_q} + (net_q ? {1'b0, tare_q} : '0);
    gross_pm = {11'h000, gross} * 36'(11'h3E8);
    limit_pm = {12'h000, cap_q} * {25'h0000000, ovr_pm_q};
    overrange = gross_pm > limit_pm;
    acc_sum = {1'b0, acc_q} + {1'b0, weight_q};
    acc_overflow = acc_sum > {1'b0, scale_msg_pkg::ACC_MAX};
    cal_rise = cal_s2_q && !cal_s3_q;
    cal_fall = !cal_s2_q && cal_s3_q;
  end

  always_comb begin
    boot_d = boot_q;
    code_d = code_q;
    svc_d = svc_q;
    print_pend_d = print_pend_q && !print_fault_ready;
    boot_cal_d = boot_cal_q;
    notice_d = notice_q;
    ntimer_d = ntimer_q;
    shutoff_d = shutoff_q;
    weight_d = weight_q;
    calnum_d = calnum_q;
    acc_full_d = acc_full_q;
    acc_d = acc_q;
    bat_low_d = bat_low_q;
    ev = '0;
    case (boot_q)
      ST_SELFTEST: begin
        if (selftest_done) begin
          if (mem_fail || prog_fail || backup_lost || backup_store_fail) begin
            boot_d = ST_FAULT;
            print_pend_d = 1'b1;
            ev[scale_msg_pkg::EV_FAULT] = 1'b1;
            if (mem_fail) begin
              code_d = scale_msg_pkg::FAULT_MEM;
            end else if (prog_fail) begin
              code_d = scale_msg_pkg::FAULT_PROG;
            end else if (backup_lost) begin
              code_d = scale_msg_pkg::FAULT_BACKUP_LOST;
            end else begin
              code_d = scale_msg_pkg::FAULT_BACKUP_STORE;
              svc_d = backup_service;
            end
          end else begin
            boot_d = ST_RUN;
            boot_cal_d = cal_s2_q;
          end
        end
      end
      ST_FAULT: begin
        boot_d = ST_FAULT;
      end
      ST_RUN: begin
        if (boot_cal_q) begin
          boot_cal_d = 1'b0;
          notice_d = scale_msg_pkg::MSG_CAL_ON;
          ntimer_d = NOTICE_CYCLES;
          ev[scale_msg_pkg::EV_CAL] = 1'b1;
        end else if (cal_rise) begin
          notice_d = scale_msg_pkg::MSG_CAL_ON;
          ntimer_d = NOTICE_CYCLES;
          ev[scale_msg_pkg::EV_CAL] = 1'b1;
        end else if (cal_fall) begin
          notice_d = scale_msg_pkg::MSG_CAL_OFF;
          ntimer_d = NOTICE_CYCLES;
          ev[scale_msg_pkg::EV_CAL] = 1'b1;
        end else if (ntimer_q != 32'h00000000) begin
          ntimer_d = ntimer_q - 32'h00000001;
          if (ntimer_q == 32'h00000001) begin
            notice_d = scale_msg_pkg::MSG_WEIGHT;
            acc_full_d = 1'b0;
          end
        end
        if (frame_valid) begin
          if (frame_access != acc_s2_q) begin
            boot_d = ST_FAULT;
            code_d = scale_msg_pkg::FAULT_ACCESS;
            print_pend_d = 1'b1;
            ev[scale_msg_pkg::EV_FAULT] = 1'b1;
          end else begin
            shutoff_d = frame_shutoff;
            if (frame_shutoff) begin
              ev[scale_msg_pkg::EV_SHUTOFF] = 1'b1;
            end
            weight_d = frame_weight;
            bat_low_d = frame_bat_minutes <= scale_msg_pkg::LOWBAT_MIN_V;
            if (frame_powerup) begin
              calnum_d = frame_calnum;
              notice_d = scale_msg_pkg::MSG_CALNUM;
              ntimer_d = NOTICE_CYCLES;
            end
          end
        end
        if (accumulate_req && ntimer_q == 32'h00000000) begin
          if (acc_overflow) begin
            acc_full_d = 1'b1;
            notice_d = scale_msg_pkg::MSG_OVERRANGE;
            ntimer_d = NOTICE_CYCLES;
            ev[scale_msg_pkg::EV_ACC_FULL] = 1'b1;
          end else begin
            acc_d = acc_sum[WW-1:0];
          end
        end
      end
      default: boot_d = ST_SELFTEST;
    endcase
    if (overrange) begin
      ev[scale_msg_pkg::EV_OVR] = 1'b1;
    end
    if (signal_lost && boot_q == ST_RUN) begin
      ev[scale_msg_pkg::EV_LOS] = 1'b1;
    end
    if (reg_wr && reg_addr == scale_msg_pkg::REG_CTRL && reg_wdata[scale_msg_pkg::CTRL_ACC_CLEAR]) begin
      acc_d = '0;
    end
  end

  // Marching hyphen position and lamp flasher on divided enables
  always_comb begin
    march_cnt_d = march_cnt_q + 32'h00000001;
    march_d = march_q;
    if (march_cnt_q >= MARCH_CYCLES - 1) begin
      march_cnt_d = '0;
      march_d = (march_q == 4'h5) ? 4'h0 : march_q + 4'h1;
    end
    flash_cnt_d = flash_cnt_q + 32'h00000001;
    flash_d = flash_q;
    if (flash_cnt_q >= FLASH_CYCLES - 1) begin
      flash_cnt_d = '0;
      flash_d = !flash_q;
    end
  end

  // Register writes and sticky interrupt status
  always_comb begin
    net_d = net_q;
    ovr_pm_d = ovr_pm_q;
    cap_d = cap_q;
    tare_d = tare_q;
    ien_d = ien_q;
    ist_d = ist_q;
    if (reg_wr) begin
      case (reg_addr)
        scale_msg_pkg::REG_CTRL: begin
          net_d = reg_wdata[scale_msg_pkg::CTRL_NET];
          ovr_pm_d = reg_wdata[scale_msg_pkg::CTRL_OVR_LO +: 11];
        end
        scale_msg_pkg::REG_CAPACITY: cap_d = reg_wdata[WW-1:0];
        scale_msg_pkg::REG_TARE: tare_d = reg_wdata[WW-1:0];
        scale_msg_pkg::REG_INT_EN: ien_d = reg_wdata[EW-1:0];
        scale_msg_pkg::REG_INT_CLR: ist_d = ist_q & ~reg_wdata[EW-1:0];
        default: ist_d = ist_q;
      endcase
    end
    ist_d = ist_d | ev;
  end

  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        scale_msg_pkg::REG_CTRL: rdata_d = {13'h0000, ovr_pm_q, 7'h00, net_q};
        scale_msg_pkg::REG_CAPACITY: rdata_d = {8'h00, cap_q};
        scale_msg_pkg::REG_TARE: rdata_d = {8'h00, tare_q};
        scale_msg_pkg::REG_ACC: rdata_d = {8'h00, acc_q};
        scale_msg_pkg::REG_STATUS: rdata_d = {25'h0000000, bat_low_q, shutoff_q, acc_full_q,
                                              signal_lost, overrange, boot_q == ST_FAULT, boot_q == ST_RUN};
        scale_msg_pkg::REG_INT_STAT: rdata_d = {26'h0000000, ist_q};
        scale_msg_pkg::REG_INT_EN: rdata_d = {26'h0000000, ien_q};
        scale_msg_pkg::REG_FAULT: rdata_d = {16'h0000, code_q, svc_q};
        scale_msg_pkg::REG_CALNUM: rdata_d = {8'h00, calnum_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      net_q <= 1'b0;
      ovr_pm_q <= scale_msg_pkg::OVR_PERMILLE_DEF;
      cap_q <= scale_msg_pkg::CAPACITY_DEF;
      tare_q <= '0;
      acc_q <= '0;
      ist_q <= '0;
      ien_q <= '0;
      reg_rdata <= '0;
      boot_q <= ST_SELFTEST;
      code_q <= '0;
      svc_q <= '0;
      print_pend_q <= 1'b0;
      boot_cal_q <= 1'b0;
      notice_q <= scale_msg_pkg::MSG_WEIGHT;
      ntimer_q <= '0;
      shutoff_q <= 1'b0;
      weight_q <= '0;
      calnum_q <= '0;
      acc_full_q <= 1'b0;
      march_cnt_q <= '0;
      flash_cnt_q <= '0;
      march_q <= '0;
      flash_q <= 1'b0;
      bat_low_q <= 1'b0;
    end else begin
      net_q <= net_d;
      ovr_pm_q <= ovr_pm_d;
      cap_q <= cap_d;
      tare_q <= tare_d;
      acc_q <= acc_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      reg_rdata <= rdata_d;
      boot_q <= boot_d;
      code_q <= code_d;
      svc_q <= svc_d;
      print_pend_q <= print_pend_d;
      boot_cal_q <= boot_cal_d;
      notice_q <= notice_d;
      ntimer_q <= ntimer_d;
      shutoff_q <= shutoff_d;
      weight_q <= weight_d;
      calnum_q <= calnum_d;
      acc_full_q <= acc_full_d;
      march_cnt_q <= march_cnt_d;
      flash_cnt_q <= flash_cnt_d;
      march_q <= march_d;
      flash_q <= flash_d;
      bat_low_q <= bat_low_d;
    end
  end

  // Display priority: fault, self-test (lost link), shutoff, lost link, notices, overrange, weight
  always_comb begin
    display_msg = scale_msg_pkg::MSG_WEIGHT;
    if (boot_q == ST_FAULT) begin
      display_msg = scale_msg_pkg::MSG_FAULT;
    end else if (boot_q == ST_SELFTEST) begin
      display_msg = scale_msg_pkg::MSG_LOS;
    end else if (shutoff_q) begin
      display_msg = scale_msg_pkg::MSG_SHUTOFF;
    end else if (signal_lost) begin
      display_msg = scale_msg_pkg::MSG_LOS;
    end else if (ntimer_q != 32'h00000000) begin
      display_msg = notice_q;
    end else if (overrange) begin
      display_msg = scale_msg_pkg::MSG_OVERRANGE;
    end
  end

  assign display_value = (notice_q == scale_msg_pkg::MSG_CALNUM) ? calnum_q : weight_q;
  assign fault_code = code_q;
  assign fault_service = svc_q;
  assign march_pos = march_q;
  assign low_battery_lamp = bat_low_q && flash_q;
  assign weighing_enable = (boot_q == ST_RUN);
  assign print_fault_valid = print_pend_q;
  assign print_fault_word = {code_q, svc_q};
  assign irq = |(ist_q & ien_q);

endmodule : scale_status_message_logic

//--- dv/scale_status_message_logic_checker.sv
`timescale 1ns/1ps
module scale_msg_checker #(
  parameter int MARCH_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Link, pins and self-test
  input wire logic frame_valid,
  input wire logic [4:0] frame_access,
  input wire logic frame_shutoff,
  input wire logic signal_lost,
  input wire logic [4:0] access_switch,
  input wire logic selftest_done,
  input wire logic mem_fail,
  input wire logic prog_fail,
  input wire logic backup_lost,
  input wire logic backup_store_fail,
  // Display and printer
  input scale_msg_pkg::msg_e display_msg,
  input wire logic [3:0] fault_code,
  input wire logic [3:0] march_pos,
  input wire logic weighing_enable,
  input wire logic print_fault_valid,
  input wire logic print_fault_ready,
  input wire logic [15:0] print_fault_word
);
  localparam scale_msg_pkg::msg_e FLT = scale_msg_pkg::MSG_FAULT;
  localparam scale_msg_pkg::msg_e LOS = scale_msg_pkg::MSG_LOS;
  logic st;
  logic flt;
  logic los_run;
  logic [3:0] pm_q;
  logic [7:0] mc_q;
  logic [7:0] mc_d;
  assign flt = display_msg == FLT;
  assign st = !weighing_enable && !flt;
  assign los_run = weighing_enable && signal_lost && display_msg == LOS;
  // Cycles the hyphens have stood still while the link is down
  always_comb mc_d = (los_run && march_pos == pm_q) ? mc_q + 8'h1 : 8'h0;
  always_ff @(posedge clk) begin
    pm_q <= march_pos;
    mc_q <= rstn ? mc_d : 8'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_fault_hold;
    flt |=> flt;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault message dropped");
  property p_fault_stop;
    flt |-> !weighing_enable;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("weighing during fault");
  property p_code;
    flt |-> fault_code inside {[4'h1:4'h5]};
  endproperty
  a_code: assert property (p_code) else $error("fault without code");
  property p_st_fail;
    st && selftest_done && mem_fail |=> flt && fault_code == 4'h1;
  endproperty
  a_st_fail: assert property (p_st_fail) else $error("memory fault missed");
  property p_st_pass;
    st && selftest_done && !(mem_fail || prog_fail || backup_lost || backup_store_fail) |=> weighing_enable && !flt;
  endproperty
  a_st_pass: assert property (p_st_pass) else $error("start-up did not continue");
  property p_prn_hold;
    print_fault_valid && !print_fault_ready |=> print_fault_valid && $stable(print_fault_word);
  endproperty
  a_prn_hold: assert property (p_prn_hold) else $error("printer word not held");
  property p_prn_code;
    print_fault_valid |-> print_fault_word[15:12] == fault_code;
  endproperty
  a_prn_code: assert property (p_prn_code) else $error("printer code differs");
  property p_shut;
    weighing_enable && frame_valid && frame_shutoff && frame_access == access_switch
      |=> display_msg == scale_msg_pkg::MSG_SHUTOFF;
  endproperty
  a_shut: assert property (p_shut) else $error("shutoff notice missed");
  property p_march_pos;
    display_msg == LOS && weighing_enable |-> march_pos <= 4'h5;
  endproperty
  a_march_pos: assert property (p_march_pos) else $error("hyphen off display");
  property p_march_run;
    mc_q <= 8'(MARCH_CYCLES);
  endproperty
  a_march_run: assert property (p_march_run) else $error("hyphens not marching");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : scale_msg_checker

bind scale_status_message_logic scale_msg_checker #(.MARCH_CYCLES(MARCH_CYCLES)) u_chk (
  .clk, .rstn, .reg_rd, .reg_rdata, .frame_valid, .frame_access, .frame_shutoff, .signal_lost,
  .access_switch, .selftest_done, .mem_fail, .prog_fail, .backup_lost, .backup_store_fail,
  .display_msg, .fault_code, .march_pos, .weighing_enable, .print_fault_valid, .print_fault_ready,
  .print_fault_word
);

//--- dv/remote_unit_model.sv
`timescale 1ns/1ps
module remote_unit_model (
  // Clock
  input wire logic clk,
  // Access code carried by every frame
  input wire logic [4:0] code,
  // Decoded frames
  output logic frame_valid,
  output logic [23:0] frame_weight,
  output logic [4:0] frame_access,
  output logic frame_shutoff,
  output logic frame_powerup,
  output logic [23:0] frame_calnum,
  output logic [7:0] frame_bat_minutes,
  output logic signal_lost
);
  initial begin
    frame_valid = 1'b0;
    frame_weight = 24'h0;
    frame_access = 5'h0;
    frame_shutoff = 1'b0;
    frame_powerup = 1'b0;
    frame_calnum = 24'h0;
    frame_bat_minutes = 8'hFF;
    signal_lost = 1'b0;
  end
  task automatic send(input logic [23:0] w, input logic [7:0] bat, input logic sh, input logic pu);
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_weight <= w;
    frame_access <= code;
    frame_shutoff <= sh;
    frame_powerup <= pu;
    frame_calnum <= w;
    frame_bat_minutes <= bat;
    @(posedge clk);
    // Stale weight, access and calibration fields are scrambled so nothing reads them by luck
    frame_valid <= 1'b0;
    frame_weight <= ~w;
    frame_access <= ~code;
    frame_calnum <= ~w;
  endtask : send
  task automatic lose;
    @(posedge clk);
    signal_lost <= 1'b1;
  endtask : lose
  // Shutoff notice is the last frame, then the link falls silent
  task automatic power_off;
    send(24'h0, 8'h0, 1'b1, 1'b0);
    signal_lost <= 1'b1;
  endtask : power_off
  task automatic power_on(input logic [23:0] cal);
    @(posedge clk);
    signal_lost <= 1'b0;
    send(cal, 8'hC8, 1'b0, 1'b1);
  endtask : power_on
endmodule : remote_unit_model

//--- dv/scale_status_message_logic_bench.sv
`timescale 1ns/1ps
module scale_status_message_logic_bench;
  localparam int NC = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic accumulate_req = 1'b0;
  logic cal_switch = 1'b0;
  logic selftest_done = 1'b0;
  logic print_fault_ready = 1'b0;
  logic [4:0] access_switch = 5'h0A;
  logic [4:0] code = 5'h0A;
  logic [3:0] fails = 4'h0;
  logic [11:0] svc = 12'h0;
  logic frame_valid, frame_shutoff, frame_powerup, signal_lost, low_battery_lamp, weighing_enable;
  logic print_fault_valid, irq, s;
  logic [23:0] frame_weight, frame_calnum, display_value, c;
  logic [4:0] frame_access;
  logic [7:0] frame_bat_minutes;
  logic [3:0] fault_code, march_pos, m;
  logic [11:0] fault_service;
  logic [15:0] print_fault_word;
  logic [31:0] reg_rdata, rd;
  scale_msg_pkg::msg_e display_msg;
  int num_errors = 0;
  int n_tests = 0;
  int w;
  always #20 clk = ~clk;
  scale_status_message_logic #(.NOTICE_CYCLES(NC), .MARCH_CYCLES(4), .FLASH_CYCLES(4)) DUT (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_valid, .frame_weight,
    .frame_access, .frame_shutoff, .frame_powerup, .frame_calnum, .frame_bat_minutes, .signal_lost,
    .accumulate_req, .cal_switch, .access_switch, .selftest_done, .mem_fail(fails[0]),
    .prog_fail(fails[1]), .backup_lost(fails[2]), .backup_store_fail(fails[3]), .backup_service(svc),
    .display_msg, .display_value, .fault_code, .fault_service, .march_pos, .low_battery_lamp,
    .weighing_enable, .print_fault_valid, .print_fault_ready, .print_fault_word, .irq
  );
  remote_unit_model rem (
    .clk, .code, .frame_valid, .frame_weight, .frame_access, .frame_shutoff, .frame_powerup,
    .frame_calnum, .frame_bat_minutes, .signal_lost
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  function automatic scale_msg_pkg::msg_e ovr(input int g);
    return (g * 1000 > 10000 * 1040) ? scale_msg_pkg::MSG_OVERRANGE : scale_msg_pkg::MSG_WEIGHT;
  endfunction : ovr
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask : rdr
  task automatic wait_msg(input scale_msg_pkg::msg_e e, input int lim);
    for (int i = 0; i < lim && display_msg !== e; i++)
      @(negedge clk);
    chk(32'(display_msg), 32'(e));
  endtask : wait_msg
  task automatic boot(input logic [3:0] f);
    @(posedge clk);
    rstn <= 1'b0;
    fails <= f;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // Let the calibration pin pass its synchroniser during self-test
    repeat (4) @(posedge clk);
    selftest_done <= 1'b1;
    @(posedge clk);
    selftest_done <= 1'b0;
    @(negedge clk);
  endtask : boot
  task automatic fr(input logic [23:0] v, input logic [7:0] b);
    rem.send(v, b, 1'b0, 1'b0);
    @(negedge clk);
  endtask : fr
  task automatic acc;
    @(posedge clk);
    accumulate_req <= 1'b1;
    @(posedge clk);
    accumulate_req <= 1'b0;
  endtask : acc
  task automatic lamp(output logic seen);
    seen = 1'b0;
    repeat (12) begin
      @(negedge clk);
      seen |= low_battery_lamp;
    end
  endtask : lamp
  initial begin
    void'($urandom(66925));
    boot(4'h0);
    chk(weighing_enable, 1'b1);
    rdr(4'h0);
    chk(rd, 32'h41000);
    rdr(4'h1);
    chk(rd, 32'h2710);
    rdr(4'hF);
    chk(rd, 32'h0);
    $display("register test done");
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 10400 : (i == 1) ? 10401 : 10380 + $urandom % 41;
      fr(24'(w), 8'hC8);
      wait_msg(ovr(w), 0);
    end
    wr(4'h2, 32'h3E8);
    wr(4'h0, 32'h41001);
    fr(24'd9401, 8'hC8);
    wait_msg(ovr(10401), 0);
    fr(24'd9400, 8'hC8);
    wait_msg(ovr(10400), 0);
    wr(4'h0, 32'h41000);
    $display("overrange test done");
    rem.lose();
    wait_msg(scale_msg_pkg::MSG_LOS, 4);
    m = march_pos;
    repeat (5) @(negedge clk);
    chk(march_pos != m, 1'b1);
    c = 24'($urandom % 10400);
    rem.power_on(c);
    wait_msg(scale_msg_pkg::MSG_CALNUM, 2);
    chk(display_value, c);
    rdr(4'h9);
    chk(rd, {8'h00, c});
    wait_msg(scale_msg_pkg::MSG_WEIGHT, NC + 4);
    rem.power_off();
    wait_msg(scale_msg_pkg::MSG_SHUTOFF, 2);
    repeat (6) @(negedge clk);
    wait_msg(scale_msg_pkg::MSG_SHUTOFF, 0);
    rem.power_on(24'h123);
    wait_msg(scale_msg_pkg::MSG_WEIGHT, NC + 6);
    $display("link test done");
    @(posedge clk);
    cal_switch <= 1'b1;
    wait_msg(scale_msg_pkg::MSG_CAL_ON, 8);
    wait_msg(scale_msg_pkg::MSG_WEIGHT, NC + 4);
    @(posedge clk);
    cal_switch <= 1'b0;
    wait_msg(scale_msg_pkg::MSG_CAL_OFF, 8);
    repeat (NC - 4) @(negedge clk);
    wait_msg(scale_msg_pkg::MSG_CAL_OFF, 0);
    wait_msg(scale_msg_pkg::MSG_WEIGHT, 8);
    $display("calibration test done");
    wr(4'h1, 32'hFFFFFF);
    wr(4'h6, 32'h0);
    fr(24'h98967F, 8'hC8);
    acc();
    rdr(4'h3);
    chk(rd, 32'h98967F);
    fr(24'h1, 8'hC8);
    acc();
    wait_msg(scale_msg_pkg::MSG_OVERRANGE, 3);
    rdr(4'h3);
    chk(rd, 32'h98967F);
    chk(irq, 1'b0);
    wr(4'h6, 32'h2);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(4'h7, 32'h2);
    rdr(4'h5);
    chk(rd[1], 1'b0);
    chk(irq, 1'b0);
    wr(4'h0, 32'h41002);
    rdr(4'h3);
    chk(rd, 32'h0);
    $display("accumulator test done");
    wait_msg(scale_msg_pkg::MSG_WEIGHT, NC + 4);
    fr(24'h10, 8'd90);
    lamp(s);
    chk(s, 1'b1);
    fr(24'h10, 8'd91);
    @(negedge clk);
    lamp(s);
    chk(s, 1'b0);
    $display("battery test done");
    for (int k = 1; k <= 5; k++) begin
      @(posedge clk);
      svc <= 12'($urandom);
      boot(k == 5 ? 4'h0 : k == 1 ? 4'hF : 4'h1 << (k - 1));
      if (k == 5) begin
        code <= 5'h15;
        fr(24'h5, 8'hC8);
      end
      wait_msg(scale_msg_pkg::MSG_FAULT, 2);
      chk(fault_code, 32'(k));
      if (k == 4) begin
        chk(fault_service, svc);
        rdr(4'h8);
        chk(rd, {16'h0000, 4'h4, svc});
      end
      if (k < 5) begin
        repeat (3) @(negedge clk);
        chk(print_fault_valid, 1'b1);
        chk(print_fault_word[15:12], 32'(k));
        @(posedge clk);
        print_fault_ready <= 1'b1;
        @(posedge clk);
        print_fault_ready <= 1'b0;
        @(negedge clk);
        chk(print_fault_valid, 1'b0);
        rdr(4'h4);
        chk(rd, 32'h00000002);
      end
      code <= 5'h0A;
      fr(24'h5, 8'hC8);
      wait_msg(scale_msg_pkg::MSG_FAULT, 0);
      chk(weighing_enable, 1'b0);
    end
    $display("fault test done");
    @(posedge clk);
    cal_switch <= 1'b1;
    boot(4'h0);
    wait_msg(scale_msg_pkg::MSG_CAL_ON, 8);
    $display("power-up calibration test done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : scale_status_message_logic_bench
